// file: spf_defines.vh
/*
  Shared constants of the slot power fault protection block: register byte
  offsets, field positions, reset values and the nominal regulation timeouts.
  Assumes a 250 MHz clock and a 32-bit AHB-Lite register bus.
*/
`ifndef SPF_DEFINES_VH
`define SPF_DEFINES_VH

// register byte offsets
`define SPF_CTRL_A 8'h00
`define SPF_CTRL_B 8'h04
`define SPF_STAT_A 8'h08
`define SPF_STAT_B 8'h0c
`define SPF_COMMON 8'h10
`define SPF_TSEL_A 8'h14
`define SPF_TSEL_B 8'h18

// field positions
`define SPF_CTRL_MAIN 0
`define SPF_CTRL_AUX 1
`define SPF_ST_MAIN 0
`define SPF_ST_AUX 2
`define SPF_ST_HOT 4
`define SPF_ST_MAIN_ON 6
`define SPF_ST_AUX_ON 7
`define SPF_CS_DIE_HOT 1
`define SPF_CS_SUPPRESS 3

// reset values
`define SPF_CTRL_RST 2'h0
`define SPF_TSEL_RST 3'h0
`define SPF_CS_SUPPRESS_RST 1'h0

// timing: clock rate and nominal timeouts in microseconds
`define SPF_CLK_MHZ 250
`define SPF_TF0_US 10
`define SPF_TF1_US 5000
`define SPF_TF2_US 11000
`define SPF_TF3_US 24000
`define SPF_TF4_US 50000

// the same timeouts in clock cycles at that rate, sized for the 24-bit timer
`define SPF_TF0_CYC 24'h0009c4
`define SPF_TF1_CYC 24'h1312d0
`define SPF_TF2_CYC 24'h29f630
`define SPF_TF3_CYC 24'h5b8d80
`define SPF_TF4_CYC 24'hbebc20

`endif

// file: spf_reg_timer.v
/*
  Regulation timeout counter for one slot.
  Assumes run is a clean synchronous level; limit is at least one cycle.
*/
`timescale 1ns/10ps
module spf_reg_timer #(
  parameter CW = 24
) (
  input wire clock,
  input wire rst_n,
  input wire run,
  input wire [CW-1:0] limit,
  output reg expired
);

reg [CW-1:0] count;

////////////////////////////////////////////////////////////////////////
// count while regulating; any break restarts the episode, so short
// transients never accumulate toward a trip
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    count <= {CW{1'b0}};
    expired <= 1'b0;
  end else if (!run) begin
    count <= {CW{1'b0}};
    expired <= 1'b0;
  end else if (count + {{(CW-1){1'b0}}, 1'b1} >= limit) begin
    expired <= 1'b1; // holds until regulation ends
  end else begin
    count <= count + {{(CW-1){1'b0}}, 1'b1};
  end
end

endmodule // spf_reg_timer

// file: spf_top.v
/*
  Two-slot fault protection and shutdown control with an AHB-Lite register
  slave. Assumes sensing flags, pins and bus are synchronous to clock and
  that the slave is the only one on its bus.
*/
`timescale 1ns/10ps
`include "spf_defines.vh"
module spf_top #(
  parameter [23:0] TF0_CYC = `SPF_TF0_CYC,
  parameter [23:0] TF1_CYC = `SPF_TF1_CYC,
  parameter [23:0] TF2_CYC = `SPF_TF2_CYC,
  parameter [23:0] TF3_CYC = `SPF_TF3_CYC,
  parameter [23:0] TF4_CYC = `SPF_TF4_CYC
) (
  input wire clock,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [1:0] main_on_pin,
  input wire [1:0] auxiliary_enable_pin,
  input wire [3:0] main_over_limit,
  input wire [3:0] gross_overcurrent_trip,
  input wire [1:0] standby_over_limit,
  input wire [1:0] slot_overheat,
  input wire die_overheat_flag,
  output reg [1:0] main_gate_on,
  output reg [1:0] standby_output,
  output reg [1:0] main_discharge,
  output reg [1:0] standby_discharge,
  output reg [1:0] fault_n,
  output reg irq_n
);

////////////////////////////////////////////////////////////////////////
// register state
reg [1:0] ctrl_main;
reg [1:0] ctrl_aux;
reg [5:0] tsel;
reg [1:0] st_main;
reg [1:0] st_aux;
reg [1:0] st_hot;
reg cs_die_hot;
reg irq_suppress_bit;
reg [1:0] main_trip;
reg [1:0] aux_trip;
reg [1:0] fault_main;
reg [1:0] fault_aux;

// bus data phase state
reg wr_pend;
reg [2:0] wr_idx;

////////////////////////////////////////////////////////////////////////
// address decode: bit 3 flags a mapped word, low bits give its index
function [3:0] spf_decode;
  input [31:0] addr;
  begin
    if (addr[31:5] == 27'h0 && addr[1:0] == 2'h0 && addr[4:2] != 3'h7)
      spf_decode = {1'b1, addr[4:2]};
    else
      spf_decode = 4'h0;
  end
endfunction

// decoder key of a byte offset; keeps the compare at four bits
function [3:0] spf_key;
  input [7:0] off;
  begin
    spf_key = {1'b1, off[4:2]};
  end
endfunction

localparam [3:0] K_CTRL_A = spf_key(`SPF_CTRL_A);
localparam [3:0] K_CTRL_B = spf_key(`SPF_CTRL_B);
localparam [3:0] K_STAT_A = spf_key(`SPF_STAT_A);
localparam [3:0] K_STAT_B = spf_key(`SPF_STAT_B);
localparam [3:0] K_COMMON = spf_key(`SPF_COMMON);
localparam [3:0] K_TSEL_A = spf_key(`SPF_TSEL_A);
localparam [3:0] K_TSEL_B = spf_key(`SPF_TSEL_B);

// regulation timeout for a setting; unknown settings take the longest
function [23:0] spf_limit;
  input [2:0] sel;
  begin
    case (sel)
      3'h0: spf_limit = TF0_CYC;
      3'h1: spf_limit = TF1_CYC;
      3'h2: spf_limit = TF2_CYC;
      3'h3: spf_limit = TF3_CYC;
      default: spf_limit = TF4_CYC;
    endcase
  end
endfunction

wire ap_valid = hsel & htrans[1] & hready;
wire [3:0] ap_dec = spf_decode(haddr);
wire [3:0] dp_dec = {wr_pend, wr_idx};

////////////////////////////////////////////////////////////////////////
// requests: pin or management bit turns an output on
wire [1:0] main_req = main_on_pin | ctrl_main;
wire [1:0] aux_req = auxiliary_enable_pin | ctrl_aux;
wire [1:0] main_active = main_req & ~main_trip;
wire [1:0] aux_active = aux_req & ~aux_trip;
wire [1:0] trip_m;
wire [1:0] trip_a;

genvar s;
generate
  for (s = 0; s < 2; s = s + 1) begin : g_slot
    wire expired;
    wire m_over = main_active[s] & (|main_over_limit[2*s +: 2]);
    wire a_over = aux_active[s] & standby_over_limit[s];
    wire fast = |gross_overcurrent_trip[2*s +: 2];
    spf_reg_timer #(
      .CW(24)
    ) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .run(m_over | a_over),
      .limit(spf_limit(tsel[3*s +: 3])),
      .expired(expired)
    );
    assign trip_m[s] = main_active[s] & (fast | (expired & m_over) | slot_overheat[s] | die_overheat_flag);
    assign trip_a[s] = aux_active[s] & ((expired & a_over) | slot_overheat[s] | die_overheat_flag);
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// trip latches and fault pin state; a new trip wins over its clear
integer i;
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    main_trip <= 2'h0;
    aux_trip <= 2'h0;
    fault_main <= 2'h0;
    fault_aux <= 2'h0;
  end else begin
    for (i = 0; i < 2; i = i + 1) begin
      if (trip_m[i])
        main_trip[i] <= 1'b1;
      else if (!main_req[i])
        main_trip[i] <= 1'b0;
      if (trip_a[i])
        aux_trip[i] <= 1'b1;
      else if (!aux_req[i])
        aux_trip[i] <= 1'b0;
      if (trip_m[i] && main_on_pin[i])
        fault_main[i] <= 1'b1;
      else if (!main_on_pin[i])
        fault_main[i] <= 1'b0;
      if (trip_a[i] && auxiliary_enable_pin[i])
        fault_aux[i] <= 1'b1;
      else if (!auxiliary_enable_pin[i])
        fault_aux[i] <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// pins; gate and discharge flops update on the same edge as the trip latches, fault_n and irq_n one edge later
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    main_gate_on <= 2'h0;
    standby_output <= 2'h0;
    main_discharge <= 2'h3;
    standby_discharge <= 2'h3;
    fault_n <= 2'h3;
    irq_n <= 1'b1;
  end else begin
    main_gate_on <= main_active & ~trip_m;
    standby_output <= aux_active & ~trip_a;
    main_discharge <= ~(main_active & ~trip_m);
    standby_discharge <= ~(aux_active & ~trip_a);
    fault_n <= ~(fault_main | fault_aux);
    irq_n <= ~((|{st_main, st_aux, st_hot, cs_die_hot}) & ~irq_suppress_bit);
  end
end

////////////////////////////////////////////////////////////////////////
// control and setting registers, written in the data phase
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    ctrl_main <= `SPF_CTRL_RST;
    ctrl_aux <= `SPF_CTRL_RST;
    tsel <= {`SPF_TSEL_RST, `SPF_TSEL_RST};
    irq_suppress_bit <= `SPF_CS_SUPPRESS_RST;
  end else if (wr_pend) begin
    case (dp_dec)
      K_CTRL_A: begin
        ctrl_main[0] <= hwdata[`SPF_CTRL_MAIN];
        ctrl_aux[0] <= hwdata[`SPF_CTRL_AUX];
      end
      K_CTRL_B: begin
        ctrl_main[1] <= hwdata[`SPF_CTRL_MAIN];
        ctrl_aux[1] <= hwdata[`SPF_CTRL_AUX];
      end
      K_TSEL_A: begin
        tsel[2:0] <= hwdata[2:0];
      end
      K_TSEL_B: begin
        tsel[5:3] <= hwdata[2:0];
      end
      K_COMMON: begin
        irq_suppress_bit <= hwdata[`SPF_CS_SUPPRESS];
      end
      default: begin
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// sticky fault bits: slot bits set when management enabled the output, the die bit
// on any die heat; cleared by writing a one back; a set in the same cycle wins
wire [1:0] clr_stat;
assign clr_stat[0] = wr_pend && dp_dec == K_STAT_A;
assign clr_stat[1] = wr_pend && dp_dec == K_STAT_B;
wire clr_cs = wr_pend && dp_dec == K_COMMON;
integer j; // own loop index, so no variable is shared between processes

always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    st_main <= 2'h0;
    st_aux <= 2'h0;
    st_hot <= 2'h0;
    cs_die_hot <= 1'b0;
  end else begin
    for (j = 0; j < 2; j = j + 1) begin
      if (trip_m[j] && ctrl_main[j])
        st_main[j] <= 1'b1;
      else if (clr_stat[j] && hwdata[`SPF_ST_MAIN])
        st_main[j] <= 1'b0;
      if (trip_a[j] && ctrl_aux[j])
        st_aux[j] <= 1'b1;
      else if (clr_stat[j] && hwdata[`SPF_ST_AUX])
        st_aux[j] <= 1'b0;
      if ((trip_m[j] && ctrl_main[j] || trip_a[j] && ctrl_aux[j]) && slot_overheat[j])
        st_hot[j] <= 1'b1;
      else if (clr_stat[j] && hwdata[`SPF_ST_HOT])
        st_hot[j] <= 1'b0;
    end
    if (die_overheat_flag)
      cs_die_hot <= 1'b1;
    else if (clr_cs && hwdata[`SPF_CS_DIE_HOT])
      cs_die_hot <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// read mux; status shows live output state in its top bits
reg [31:0] next_rdata;
always @* begin
  next_rdata = 32'h0;
  case (ap_dec)
    K_CTRL_A: next_rdata[1:0] = {ctrl_aux[0], ctrl_main[0]};
    K_CTRL_B: next_rdata[1:0] = {ctrl_aux[1], ctrl_main[1]};
    K_STAT_A: begin
      next_rdata[`SPF_ST_MAIN] = st_main[0];
      next_rdata[`SPF_ST_AUX] = st_aux[0];
      next_rdata[`SPF_ST_HOT] = st_hot[0];
      next_rdata[`SPF_ST_MAIN_ON] = main_gate_on[0];
      next_rdata[`SPF_ST_AUX_ON] = standby_output[0];
    end
    K_STAT_B: begin
      next_rdata[`SPF_ST_MAIN] = st_main[1];
      next_rdata[`SPF_ST_AUX] = st_aux[1];
      next_rdata[`SPF_ST_HOT] = st_hot[1];
      next_rdata[`SPF_ST_MAIN_ON] = main_gate_on[1];
      next_rdata[`SPF_ST_AUX_ON] = standby_output[1];
    end
    K_COMMON: begin
      next_rdata[`SPF_CS_DIE_HOT] = cs_die_hot;
      next_rdata[`SPF_CS_SUPPRESS] = irq_suppress_bit;
    end
    K_TSEL_A: next_rdata[2:0] = tsel[2:0];
    K_TSEL_B: next_rdata[2:0] = tsel[5:3];
    default: next_rdata = 32'h0;
  endcase
end

////////////////////////////////////////////////////////////////////////
// bus slave: zero wait states, always OKAY; read data is sampled in the
// address phase, so a read straight after a write sees the old value
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    hrdata <= 32'h0;
    wr_pend <= 1'b0;
    wr_idx <= 3'h0;
  end else begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    wr_pend <= ap_valid & hwrite & ap_dec[3];
    wr_idx <= ap_dec[2:0];
    if (ap_valid && !hwrite)
      hrdata <= next_rdata;
  end
end

endmodule // spf_top

// file: spf_chk_sva.sv
/* port-level assertions for spf_top, slot a plus die-wide cases.
   assumes spf_top drives its outputs from registers on clock. */
`timescale 1ns/10ps
module spf_chk (
  input wire clock,
  input wire rst_n,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [1:0] main_on_pin,
  input wire [1:0] auxiliary_enable_pin,
  input wire [3:0] gross_overcurrent_trip,
  input wire [1:0] standby_over_limit,
  input wire [1:0] slot_overheat,
  input wire die_overheat_flag,
  input wire [1:0] main_gate_on,
  input wire [1:0] standby_output,
  input wire [1:0] main_discharge,
  input wire [1:0] standby_discharge,
  input wire [1:0] fault_n,
  input wire irq_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // a write taken may release the interrupt up to three edges on
  wire wr_take = hsel && htrans[1] && hwrite && hready;
  a_fast_off: assert property (
    main_gate_on[0] && |gross_overcurrent_trip[1:0] |=> !main_gate_on[0]) else $error("fast trip kept mains");
  a_aux_no_fast: assert property (
    standby_output[0] && auxiliary_enable_pin[0] && !standby_over_limit[0] && !slot_overheat[0]
    && !die_overheat_flag |=> standby_output[0]) else $error("standby dropped without cause");
  a_die_all_off: assert property (
    die_overheat_flag |=> main_gate_on == 2'h0 && standby_output == 2'h0) else $error("die heat left output on");
  a_slot_hot_off: assert property (
    slot_overheat[0] |=> !main_gate_on[0] && !standby_output[0]) else $error("slot heat left output on");
  a_discharge_off: assert property (
    main_discharge == ~main_gate_on && standby_discharge == ~standby_output) else $error("discharge mismatch");
  a_fault_pin: assert property (
    $fell(main_gate_on[0]) && $past(main_on_pin[0]) |=> !fault_n[0]) else $error("trip without fault pin");
  a_fault_release: assert property (
    (!main_on_pin[0] && !auxiliary_enable_pin[0]) [*2] |=> fault_n[0]) else $error("fault pin not released");
  a_irq_hold: assert property (
    !irq_n && !wr_take && !$past(wr_take) && !$past(wr_take, 2) |=> !irq_n) else $error("irq released without write");
  cover property (!irq_n);
  cover property ($fell(fault_n[0]));
  cover property (die_overheat_flag && main_gate_on[1]);
endmodule // spf_chk
bind spf_top spf_chk u_chk (.*);

// file: spf_host.sv
/* host model: ahb-lite master doing single word transfers.
   assumes hready is the one slave's hreadyout. */
`timescale 1ns/10ps
module spf_host (
  input wire clock,
  input wire hready,
  input wire [31:0] hrdata,
  output reg hsel,
  output reg [31:0] haddr,
  output reg [1:0] htrans,
  output reg hwrite,
  output reg [2:0] hsize,
  output reg [31:0] hwdata
);
  reg [31:0] dummy;
  // idle bus at time zero, word size always
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////
  // whole word transfer
  // data lines show the inverse on reads so stale values never match
  task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge clock);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      htrans <= 2'h0; hwdata <= w ? d : ~hwdata;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      q = hrdata;
    end
  endtask
  task write(input [31:0] a, input [31:0] d);
    xfer(1'b1, a, d, dummy);
  endtask
  task read(input [31:0] a, output [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
endmodule // spf_host

// file: tb_top.sv
/* bench for spf_top: register table, reset, then fault scenarios.
   assumes spf_host drives the bus; short timeouts of 20..100 cycles. */
`timescale 1ns/10ps
module tb_top;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] on_pin = 2'h0;
  reg [1:0] aux_pin = 2'h0;
  reg [3:0] over = 4'h0;
  reg [3:0] fast = 4'h0;
  reg [1:0] sb_over = 2'h0;
  reg [1:0] hot = 2'h0;
  reg die = 1'b0;
  wire hsel, hwrite, hready, hresp, irq_n;
  wire [1:0] htrans, gate, sb, mdis, sdis, fault_n;
  wire [2:0] hsize;
  wire [31:0] haddr, hwdata, hrdata;
  integer bad_count = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i, s, lim;
  reg [31:0] rv;
  reg [71:0] rows [0:7];
  always #2 clock = ~clock;
  spf_top #(.TF0_CYC(24'd20), .TF1_CYC(24'd40), .TF2_CYC(24'd60), .TF3_CYC(24'd80), .TF4_CYC(24'd100)) u_dut (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .main_on_pin(on_pin),
    .auxiliary_enable_pin(aux_pin), .main_over_limit(over), .gross_overcurrent_trip(fast),
    .standby_over_limit(sb_over), .slot_overheat(hot), .die_overheat_flag(die), .main_gate_on(gate),
    .standby_output(sb), .main_discharge(mdis), .standby_discharge(sdis), .fault_n(fault_n), .irq_n(irq_n));
  spf_host u_host (.clock(clock), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  ////////////////////////////////////////////////////////////
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      u_host.read({24'h0, a}, rv);
      chk(rv, e);
    end
  endtask
  // settle one ns past the edge so design updates have landed
  task wt(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task final_report;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // hang guard, well above the thousand or so cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t timeout", $time);
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rows[0] = {8'h14, 32'hff, 32'h7}; rows[1] = {8'h14, 32'h0, 32'h0};
    rows[2] = {8'h10, 32'h8, 32'h8}; rows[3] = {8'h10, 32'h0, 32'h0};
    rows[4] = {8'h20, 32'hff, 32'h0}; rows[5] = {8'h04, 32'hf, 32'h3};
    rows[6] = {8'h0c, 32'h0, 32'hc0}; rows[7] = {8'h04, 32'h0, 32'h0};
    wt(10); rst_n <= 1'b1; wt(1);
    for (i = 0; i < 8; i = i + 1) begin
      u_host.write({24'h0, rows[i][71:64]}, rows[i][63:32]);
      rd(rows[i][71:64], rows[i][31:0]);
      chk(hresp, 32'h0);
    end
    // second reset in mid-run, then reset values of every word
    rst_n <= 1'b0; wt(2);
    chk({gate, sb, mdis, sdis, fault_n, irq_n}, 32'h7f);
    rst_n <= 1'b1; wt(1);
    for (i = 0; i < 8; i = i + 1) rd(i * 4, 32'h0);
    // fast trip under pin control, refused restart, pin cycle
    on_pin <= 2'h1; aux_pin <= 2'h1; wt(2);
    chk({gate[0], mdis[0]}, 32'h2);
    fast <= 4'h2; wt(1); fast <= 4'h0; wt(2);
    chk({gate[0], sb[0], fault_n[0], irq_n}, 32'h5);
    wt(3); chk(gate[0], 32'h0);
    on_pin <= 2'h0; wt(3); chk({gate[0], fault_n[0]}, 32'h1);
    on_pin <= 2'h1; wt(2); chk(gate[0], 32'h1);
    on_pin <= 2'h0; aux_pin <= 2'h0; wt(3);
    // timeout per setting, main on even and standby on odd settings
    for (s = 0; s < 6; s = s + 1) begin
      lim = 20 * (s > 4 ? 5 : s + 1);
      u_host.write(32'h14, s);
      on_pin <= 2'h1; aux_pin <= 2'h1; wt(3);
      over[0] <= ~s[0]; sb_over[0] <= s[0]; wt(lim - 4);
      over[0] <= 1'b0; sb_over[0] <= 1'b0; wt(2);
      chk({gate[0], sb[0]}, 32'h3);
      // still on after exactly the timeout, off one edge later
      over[0] <= ~s[0]; sb_over[0] <= s[0]; wt(lim);
      chk({gate[0], sb[0]}, 32'h3);
      wt(3); chk({gate[0], sb[0], fault_n[0]}, s[0] ? 32'h4 : 32'h2);
      over[0] <= 1'b0; sb_over[0] <= 1'b0; on_pin <= 2'h0; aux_pin <= 2'h0; wt(3);
    end
    u_host.write(32'h14, 32'h0);
    // management control: interrupt, echo clear, enable toggle, suppress
    u_host.write(32'h0, 32'h1); wt(1); chk(gate[0], 32'h1);
    fast <= 4'h1; wt(1); fast <= 4'h0; wt(3);
    chk({gate[0], fault_n[0], irq_n}, 32'h2);
    rd(8'h08, 32'h1);
    u_host.write(32'h08, 32'h1); wt(2); chk(irq_n, 32'h1);
    u_host.write(32'h0, 32'h0); u_host.write(32'h0, 32'h1); wt(1); chk(gate[0], 32'h1);
    u_host.write(32'h10, 32'h8);
    fast <= 4'h1; wt(1); fast <= 4'h0; wt(3);
    chk({gate[0], irq_n}, 32'h1);
    rd(8'h08, 32'h1);
    u_host.write(32'h08, 32'h1); u_host.write(32'h10, 32'h0); wt(2); chk(irq_n, 32'h1);
    // thermal: slot a by register, slot b by pins
    u_host.write(32'h0, 32'h0); u_host.write(32'h0, 32'h3);
    on_pin <= 2'h2; aux_pin <= 2'h2; wt(2); chk({gate, sb}, 32'hf);
    hot <= 2'h1; wt(1); hot <= 2'h0; wt(2);
    chk({gate, sb, fault_n}, 32'h2b);
    die <= 1'b1; wt(1); die <= 1'b0; wt(2);
    chk({gate, sb, fault_n}, 32'h1);
    rd(8'h10, 32'h2);
    u_host.write(32'h10, 32'h2); rd(8'h10, 32'h0);
    final_report;
  end
endmodule // tb_top
